// file: hdl/p7om_pin7_output.sv
// Purpose: Control register, Wishbone slave and pin driver for general_pin_seven
// Assumes: Classic Wishbone, 32-bit data; all sources synchronous to sys_clk
// Notes:   Pin level and enable are registered, one cycle behind the sources
`timescale 1ns/100ps

module p7om_pin7_output
(
    input  wire logic                            sys_clk,
    input  wire logic                            reset_n,
    input  wire logic [p7om_pkg::WB_ADR_W-1:0]   wb_adr_i,
    input  wire logic [p7om_pkg::WB_DAT_W-1:0]   wb_dat_i,
    input  wire logic [3:0]                      wb_sel_i,
    input  wire logic                            wb_we_i,
    input  wire logic                            wb_cyc_i,
    input  wire logic                            wb_stb_i,
    output logic      [p7om_pkg::WB_DAT_W-1:0]   wb_dat_o,
    output logic                                 wb_ack_o,
    input  p7om_pkg::p7om_rx_s                   rx_status [p7om_pkg::NUM_RX],
    input  wire logic [3:0]                      rx_port_enable,
    input  wire logic                            frame_sync_pulse,
    input  p7om_pkg::p7om_tx_s                   tx_status,
    input  wire logic                            pin_in,
    output logic                                 pin_out,
    output logic                                 pin_oe
);

    p7om_pkg::p7om_ctrl_s ctrl_r;
    logic                 ack_r;
    logic [p7om_pkg::WB_DAT_W-1:0] rdata_r;
    logic                 pin_out_r;
    logic                 pin_oe_r;
    logic                 pin_meta_r;
    logic                 pin_sync_r;
    logic                 reserved_r;
    logic                 level;
    logic                 reserved;
    logic                 req;
    logic                 hit_ctrl;
    logic                 hit_stat;
    logic [7:0]           wbyte;
    logic [7:0]           stat_word;

    assign req      = wb_cyc_i & wb_stb_i & ~ack_r;
    assign hit_ctrl = (wb_adr_i == p7om_pkg::WB_ADR_W'({p7om_pkg::CTRL_IDX, 2'b00}));
    assign hit_stat = (wb_adr_i == p7om_pkg::WB_ADR_W'({p7om_pkg::STAT_IDX, 2'b00}));
    assign wbyte    = wb_dat_i[7:0];
    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdata_r;
    assign pin_out  = pin_out_r;
    assign pin_oe   = pin_oe_r;

    always_comb
    begin
        stat_word                       = 8'h00;
        stat_word[p7om_pkg::ST_OE_BIT]  = pin_oe_r;
        stat_word[p7om_pkg::ST_OUT_BIT] = pin_out_r;
        stat_word[p7om_pkg::ST_IN_BIT]  = pin_sync_r;
        stat_word[p7om_pkg::ST_RSV_BIT] = reserved_r;
    end

    // Bus handshake: one-cycle ack, dropped the cycle after
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ack_r <= 1'b0;
        else
            ack_r <= req;
    end

    // Unmapped addresses still ack, reading zero, so a stray access never hangs
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata_r <= '0;
        else if (req && !wb_we_i)
        begin
            if (hit_ctrl)
                rdata_r <= p7om_pkg::WB_DAT_W'(ctrl_r);
            else if (hit_stat)
                rdata_r <= p7om_pkg::WB_DAT_W'(stat_word);
            else
                rdata_r <= '0;
        end
    end

    // Control register; status word is read only
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            ctrl_r <= p7om_pkg::CTRL_RST;
        else if (req && wb_we_i && wb_sel_i[0] && hit_ctrl)
            ctrl_r <= wbyte;
    end

    // Pin readback passes two flops before anything samples it
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
        end
        else
        begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    p7om_source_mux u_mux
    (
        .ctrl             (ctrl_r),
        .rx_status        (rx_status),
        .rx_port_enable   (rx_port_enable),
        .frame_sync_pulse (frame_sync_pulse),
        .tx_status        (tx_status),
        .level            (level),
        .reserved         (reserved)
    );

    // Registered drive keeps the pin glitch free while the mux settles
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pin_out_r  <= 1'b0;
            pin_oe_r   <= 1'b0;
            reserved_r <= 1'b0;
        end
        else
        begin
            pin_out_r  <= level & ~reserved;
            pin_oe_r   <= ctrl_r.pin7_drive_enable;
            reserved_r <= reserved;
        end
    end

    // Helper terms for the checks below
    p7om_pkg::p7om_rx_s pick_rx;
    logic               is_rx_grp;
    logic               exp_remote;
    logic               is_static;
    logic               is_fs;
    logic               is_tx_fv;
    logic               is_tx_irq;
    logic               is_dev_pass;
    logic               dev_pass_all;
    logic               dev_lock_any;
    logic               is_dev_lock;
    logic               is_tx_and;
    logic               is_tx_or;
    logic               is_tx_lv;
    logic               is_tx_sync;
    logic               is_rsv_sel;
    logic               tx_pass_all;
    logic               tx_pass_any;

    assign pick_rx     = rx_status[ctrl_r.pin7_source_group[1:0]];
    assign is_rx_grp   = ~ctrl_r.pin7_source_group[2];
    assign exp_remote  = pick_rx.remote_pin[ctrl_r.pin7_signal_select[1:0]];
    assign is_static   = (ctrl_r.pin7_source_group == p7om_pkg::SRC_DEV)
                       && (ctrl_r.pin7_signal_select == p7om_pkg::DSEL_VAL);
    assign is_fs       = (ctrl_r.pin7_source_group == p7om_pkg::SRC_DEV)
                       && (ctrl_r.pin7_signal_select == p7om_pkg::DSEL_FS);
    assign is_dev_lock = (ctrl_r.pin7_source_group == p7om_pkg::SRC_DEV)
                       && (ctrl_r.pin7_signal_select == p7om_pkg::DSEL_LOCK);
    assign is_dev_pass = (ctrl_r.pin7_source_group == p7om_pkg::SRC_DEV)
                       && (ctrl_r.pin7_signal_select[2:1] == 2'b01);
    assign is_tx_fv    = (ctrl_r.pin7_source_group == p7om_pkg::SRC_TX)
                       && (ctrl_r.pin7_signal_select == p7om_pkg::TSEL_FV);
    assign is_tx_irq   = (ctrl_r.pin7_source_group == p7om_pkg::SRC_TX)
                       && (ctrl_r.pin7_signal_select == p7om_pkg::TSEL_IRQ);
    assign is_tx_and   = (ctrl_r.pin7_source_group == p7om_pkg::SRC_TX)
                       && (ctrl_r.pin7_signal_select == p7om_pkg::TSEL_AND);
    assign is_tx_or    = (ctrl_r.pin7_source_group == p7om_pkg::SRC_TX)
                       && (ctrl_r.pin7_signal_select == p7om_pkg::TSEL_OR);
    assign is_tx_lv    = (ctrl_r.pin7_source_group == p7om_pkg::SRC_TX)
                       && (ctrl_r.pin7_signal_select == p7om_pkg::TSEL_LV);
    assign is_tx_sync  = (ctrl_r.pin7_source_group == p7om_pkg::SRC_TX)
                       && (ctrl_r.pin7_signal_select == p7om_pkg::TSEL_SYNC);
    assign is_rsv_sel  = ((ctrl_r.pin7_source_group == p7om_pkg::SRC_DEV)
                       && (ctrl_r.pin7_signal_select > p7om_pkg::DSEL_FS))
                       || ((ctrl_r.pin7_source_group == p7om_pkg::SRC_TX)
                       && (ctrl_r.pin7_signal_select[2:1] == 2'b11));

    always_comb
    begin
        dev_pass_all = |rx_port_enable;
        dev_lock_any = 1'b0;
        tx_pass_all  = |tx_status.pass_select;
        tx_pass_any  = 1'b0;
        for (int i = 0; i < p7om_pkg::NUM_RX; i++)
        begin
            if (tx_status.pass_select[i] && !rx_status[i].pass)
                tx_pass_all = 1'b0;
            if (tx_status.pass_select[i] && rx_status[i].pass)
                tx_pass_any = 1'b1;
            if (rx_port_enable[i] && !rx_status[i].pass)
                dev_pass_all = 1'b0;
            if (rx_port_enable[i] && rx_status[i].lock)
                dev_lock_any = 1'b1;
        end
    end

    AST_ACK_ONE_SHOT:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Wishbone ack not a single cycle after request");

    AST_RESET_DEFAULT:
    assert property (@(posedge sys_clk)
        $rose(reset_n) |-> (ctrl_r == p7om_pkg::CTRL_RST) && !pin_oe)
    else $error("Control fields or driver not cleared by reset");

    AST_DRIVE_ENABLE:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        ##1 (pin_oe == $past(ctrl_r.pin7_drive_enable)))
    else $error("Pin enable does not follow the enable bit");

    AST_RX_REMOTE_PIN:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (is_rx_grp && !ctrl_r.pin7_signal_select[2]) |=> (pin_out == $past(exp_remote)))
    else $error("Remote pin not passed from chosen receive port");

    AST_RX_LOCK:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (is_rx_grp && ctrl_r.pin7_signal_select == p7om_pkg::SEL_LOCK)
        |=> (pin_out == $past(pick_rx.lock)))
    else $error("Receive port lock not on pin");

    AST_STATIC_VALUE:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_static |=> (pin_out == $past(ctrl_r.pin7_static_value)))
    else $error("Static value bit not on pin");

    AST_DEV_LOCK_OR:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_dev_lock |=> (pin_out == $past(dev_lock_any)))
    else $error("Enabled lock OR wrong on pin");

    AST_DEV_PASS_AND:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_dev_pass |=> (pin_out == $past(dev_pass_all)))
    else $error("Enabled pass AND wrong on pin");

    AST_FRAME_SYNC:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_fs |=> (pin_out == $past(frame_sync_pulse)))
    else $error("Frame sync pulse not on pin");

    AST_TX_FRAME_VALID:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_tx_fv |=> (pin_out == $past(tx_status.frame_valid)))
    else $error("Transmit frame valid not on pin");

    AST_TX_IRQ:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_tx_irq |=> (pin_out == $past(tx_status.irq)))
    else $error("Transmit interrupt not on pin");

    AST_TX_PASS_AND:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_tx_and |=> (pin_out == $past(tx_pass_all)))
    else $error("Selected pass AND wrong on pin");

    AST_RESERVED_LOW:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ctrl_r.pin7_source_group inside {3'h5, 3'h7}) |=> !pin_out && reserved_r)
    else $error("Reserved source code does not drive low");

    AST_SOURCE_DECODE:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (ctrl_r.pin7_source_group == p7om_pkg::SRC_DEV)
        && (ctrl_r.pin7_signal_select == 3'h7) |=> reserved_r)
    else $error("Reserved status select not flagged");

    AST_WRITE_STORES:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && hit_ctrl)
        |=> (ctrl_r == $past(wbyte)) && wb_ack_o)
    else $error("Control write not stored at ack");

    AST_RX_PASS:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (is_rx_grp && ctrl_r.pin7_signal_select == p7om_pkg::SEL_PASS)
        |=> (pin_out == $past(pick_rx.pass)))
    else $error("Receive port pass not on pin");

    AST_RX_FRAME_VALID:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (is_rx_grp && ctrl_r.pin7_signal_select == p7om_pkg::SEL_FV)
        |=> (pin_out == $past(pick_rx.frame_valid)))
    else $error("Receive port frame valid not on pin");

    AST_RX_LINE_VALID:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (is_rx_grp && ctrl_r.pin7_signal_select == p7om_pkg::SEL_LV)
        |=> (pin_out == $past(pick_rx.line_valid)))
    else $error("Receive port line valid not on pin");

    AST_TX_PASS_OR:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_tx_or |=> (pin_out == $past(tx_pass_any)))
    else $error("Selected pass OR wrong on pin");

    AST_TX_LINE_VALID:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_tx_lv |=> (pin_out == $past(tx_status.line_valid)))
    else $error("Transmit line valid not on pin");

    AST_TX_SYNC:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_tx_sync |=> (pin_out == $past(tx_status.synced)))
    else $error("Synchronized flag not on pin");

    AST_RESERVED_SELECT:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_rsv_sel |=> !pin_out && reserved_r)
    else $error("Reserved select code does not drive low");

    AST_WRITE_NEEDS_SEL:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && !wb_sel_i[0]) |=> $stable(ctrl_r))
    else $error("Control changed by a write without its byte lane");

    AST_READ_CONTROL:
    assert property (@(posedge sys_clk) disable iff (!reset_n)
        (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && hit_ctrl)
        |=> (wb_dat_o == p7om_pkg::WB_DAT_W'($past(ctrl_r))))
    else $error("Control read returns a different value");

endmodule // p7om_pin7_output

// file: hdl/p7om_pkg.sv
// Purpose: Shared constants and carriers for the pin 7 output source mux
// Assumes: Registers are 8 bits wide, word aligned on a 32-bit Wishbone bus
// Notes:   Byte address of a register is four times its index
package p7om_pkg;

    localparam int            WB_ADR_W   = 8;
    localparam int            WB_DAT_W   = 32;
    localparam int            NUM_RX     = 4;
    localparam logic [7:0]    CTRL_IDX   = 8'h17;
    localparam logic [7:0]    STAT_IDX   = 8'h30;
    localparam logic [7:0]    CTRL_RST   = 8'h00;
    localparam int            SEL_LSB    = 5;
    localparam int            SRC_LSB    = 2;
    localparam int            VAL_BIT    = 1;
    localparam int            EN_BIT     = 0;
    localparam int            ST_OE_BIT  = 0;
    localparam int            ST_OUT_BIT = 1;
    localparam int            ST_IN_BIT  = 2;
    localparam int            ST_RSV_BIT = 3;

    localparam logic [2:0]    SRC_DEV    = 3'h4;
    localparam logic [2:0]    SRC_TX     = 3'h6;
    localparam logic [2:0]    SEL_LOCK   = 3'h4;
    localparam logic [2:0]    SEL_PASS   = 3'h5;
    localparam logic [2:0]    SEL_FV     = 3'h6;
    localparam logic [2:0]    SEL_LV     = 3'h7;
    localparam logic [2:0]    DSEL_VAL   = 3'h0;
    localparam logic [2:0]    DSEL_LOCK  = 3'h1;
    localparam logic [2:0]    DSEL_PASSA = 3'h2;
    localparam logic [2:0]    DSEL_PASSB = 3'h3;
    localparam logic [2:0]    DSEL_FS    = 3'h4;
    localparam logic [2:0]    TSEL_AND   = 3'h0;
    localparam logic [2:0]    TSEL_OR    = 3'h1;
    localparam logic [2:0]    TSEL_FV    = 3'h2;
    localparam logic [2:0]    TSEL_LV    = 3'h3;
    localparam logic [2:0]    TSEL_SYNC  = 3'h4;
    localparam logic [2:0]    TSEL_IRQ   = 3'h5;

    typedef struct packed {
        logic [2:0] pin7_signal_select;
        logic [2:0] pin7_source_group;
        logic       pin7_static_value;
        logic       pin7_drive_enable;
    } p7om_ctrl_s;

    typedef struct packed {
        logic [3:0] remote_pin;
        logic       lock;
        logic       pass;
        logic       frame_valid;
        logic       line_valid;
    } p7om_rx_s;

    typedef struct packed {
        logic [3:0] pass_select;
        logic       frame_valid;
        logic       line_valid;
        logic       synced;
        logic       irq;
    } p7om_tx_s;

    // Empty mask gives 0 so an idle hub never reports pass
    function automatic logic and_masked(input logic [3:0] v, input logic [3:0] m);
        and_masked = (|m) & (&(v | ~m));
    endfunction

    function automatic logic or_masked(input logic [3:0] v, input logic [3:0] m);
        or_masked = |(v & m);
    endfunction

endpackage

// file: hdl/p7om_source_mux.sv
// Purpose: Picks the level for general_pin_seven from the programmed group
// Assumes: All sources are on sys_clk
// Notes:   Purely combinational; the top registers the result
`timescale 1ns/100ps
module p7om_source_mux
(
    input  p7om_pkg::p7om_ctrl_s ctrl,
    input  p7om_pkg::p7om_rx_s   rx_status [p7om_pkg::NUM_RX],
    input  wire logic [3:0]      rx_port_enable,
    input  wire logic            frame_sync_pulse,
    input  p7om_pkg::p7om_tx_s   tx_status,
    output logic                 level,
    output logic                 reserved
);

    logic [3:0]         lock_v;
    logic [3:0]         pass_v;
    p7om_pkg::p7om_rx_s port;

    always_comb
    begin
        for (int i = 0; i < p7om_pkg::NUM_RX; i++)
        begin
            lock_v[i] = rx_status[i].lock;
            pass_v[i] = rx_status[i].pass;
        end
    end

    always_comb
    begin
        level    = 1'b0;
        reserved = 1'b0;
        port     = rx_status[ctrl.pin7_source_group[1:0]];
        if (!ctrl.pin7_source_group[2])
        begin
            case (ctrl.pin7_signal_select)
                p7om_pkg::SEL_LOCK: level = port.lock;
                p7om_pkg::SEL_PASS: level = port.pass;
                p7om_pkg::SEL_FV:   level = port.frame_valid;
                p7om_pkg::SEL_LV:   level = port.line_valid;
                default:            level = port.remote_pin[ctrl.pin7_signal_select[1:0]];
            endcase
        end
        else if (ctrl.pin7_source_group == p7om_pkg::SRC_DEV)
        begin
            case (ctrl.pin7_signal_select)
                p7om_pkg::DSEL_VAL:   level = ctrl.pin7_static_value;
                p7om_pkg::DSEL_LOCK:  level = p7om_pkg::or_masked(lock_v, rx_port_enable);
                p7om_pkg::DSEL_PASSA: level = p7om_pkg::and_masked(pass_v, rx_port_enable);
                p7om_pkg::DSEL_PASSB: level = p7om_pkg::and_masked(pass_v, rx_port_enable);
                p7om_pkg::DSEL_FS:    level = frame_sync_pulse;
                default:              reserved = 1'b1;
            endcase
        end
        else if (ctrl.pin7_source_group == p7om_pkg::SRC_TX)
        begin
            case (ctrl.pin7_signal_select)
                p7om_pkg::TSEL_AND:  level = p7om_pkg::and_masked(pass_v, tx_status.pass_select);
                p7om_pkg::TSEL_OR:   level = p7om_pkg::or_masked(pass_v, tx_status.pass_select);
                p7om_pkg::TSEL_FV:   level = tx_status.frame_valid;
                p7om_pkg::TSEL_LV:   level = tx_status.line_valid;
                p7om_pkg::TSEL_SYNC: level = tx_status.synced;
                p7om_pkg::TSEL_IRQ:  level = tx_status.irq;
                default:             reserved = 1'b1;
            endcase
        end
        else
        begin
            reserved = 1'b1;
        end
    end

endmodule // p7om_source_mux

// file: dv/p7om_board_pin.sv
// Purpose: Board side of general_pin_seven, a pad with a weak pull-down
// Assumes: Only the hub drives the pad
// Notes:   A released pad reads low, never the last driven level
`timescale 1ns/100ps
module p7om_board_pin
(
    input  wire logic pin_out,
    input  wire logic pin_oe,
    output logic      pin_level
);
    // Pull-down wins whenever the hub releases the pad
    assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule // p7om_board_pin

// file: dv/tb.sv
// Purpose: Self-checking bench for the pin 7 output source mux
// Assumes: Board pulls the pad low; status word shows oe, out, pad and reserved flag
// Notes:   Every result is checked through a register read, so the pad path is seen too
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
    $display("MISMATCH t=%0t read %h expected %h", $time, got, exp); end end
module tb;
    logic                       sys_clk;
    logic                       reset_n;
    logic [7:0]                 wb_adr_i;
    logic [31:0]                wb_dat_i;
    logic [3:0]                 wb_sel_i;
    logic                       wb_we_i;
    logic                       wb_cyc_i;
    logic                       wb_stb_i;
    logic [31:0]                wb_dat_o;
    logic                       wb_ack_o;
    p7om_pkg::p7om_rx_s         rx_status [p7om_pkg::NUM_RX];
    logic [3:0]                 rx_port_enable;
    logic                       frame_sync_pulse;
    p7om_pkg::p7om_tx_s         tx_status;
    logic                       pin_in;
    logic                       pin_out;
    logic                       pin_oe;
    int                         err_total;
    int                         tests_run;
    logic [31:0]                exp_q [$];
    logic [31:0]                exp_v;
    localparam logic [7:0]      A_CTRL = {p7om_pkg::CTRL_IDX[5:0], 2'b00};
    localparam logic [7:0]      A_STAT = {p7om_pkg::STAT_IDX[5:0], 2'b00};

    p7om_pin7_output uut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .rx_status(rx_status), .rx_port_enable(rx_port_enable),
        .frame_sync_pulse(frame_sync_pulse), .tx_status(tx_status), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe));
    p7om_board_pin board (.pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_in));

    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Single classic cycle; only the watchdog ends a wait on a dead slave
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        @(posedge sys_clk);
        while (wb_ack_o !== 1'b1)
            @(posedge sys_clk);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        exp_q.push_back(exp);
        wb_xfer(1'b0, adr, 32'h0000_0000, 4'hF);
    endtask

    task automatic shake_sources();
        for (int i = 0; i < p7om_pkg::NUM_RX; i++)
            rx_status[i] <= 8'($urandom);
        rx_port_enable   <= 4'($urandom);
        frame_sync_pulse <= 1'($urandom);
        tx_status        <= 8'($urandom);
    endtask

    // Returns {reserved, level}, worked out from the source and select tables
    function automatic logic [1:0] exp_mux(input logic [2:0] src, input logic [2:0] sel, input logic val);
        logic [3:0]         pass_v;
        logic [3:0]         lock_v;
        logic [3:0]         ps;
        p7om_pkg::p7om_rx_s r;
        for (int i = 0; i < 4; i++)
        begin
            pass_v[i] = rx_status[i].pass;
            lock_v[i] = rx_status[i].lock;
        end
        ps = tx_status.pass_select;
        r = rx_status[src[1:0]];
        exp_mux = 2'b10;
        if (!src[2])
            exp_mux = {1'b0, sel[2] ? (sel[1] ? (sel[0] ? r.line_valid : r.frame_valid)
                                              : (sel[0] ? r.pass : r.lock)) : r.remote_pin[sel[1:0]]};
        else if (src == 3'h4 && sel == 3'h0)
            exp_mux = {1'b0, val};
        else if (src == 3'h4 && sel == 3'h1)
            exp_mux = {1'b0, |(lock_v & rx_port_enable)};
        else if (src == 3'h4 && sel[2:1] == 2'b01)
            exp_mux = {1'b0, (|rx_port_enable) && ((pass_v & rx_port_enable) == rx_port_enable)};
        else if (src == 3'h4 && sel == 3'h4)
            exp_mux = {1'b0, frame_sync_pulse};
        else if (src == 3'h6 && sel == 3'h0)
            exp_mux = {1'b0, (|ps) && ((pass_v & ps) == ps)};
        else if (src == 3'h6 && sel == 3'h1)
            exp_mux = {1'b0, |(pass_v & ps)};
        else if (src == 3'h6 && sel[2:1] == 2'b01)
            exp_mux = {1'b0, sel[0] ? tx_status.line_valid : tx_status.frame_valid};
        else if (src == 3'h6 && sel[2:1] == 2'b10)
            exp_mux = {1'b0, sel[0] ? tx_status.irq : tx_status.synced};
    endfunction

    always @(posedge sys_clk)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
        begin
            exp_v = exp_q.pop_front();
            `CHK(wb_dat_o, exp_v)
        end
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        conclude();
    end

    initial
    begin
        logic [7:0] c;
        logic [1:0] m;
        reset_n  = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
        err_total = 0;
        tests_run = 0;
        void'($urandom(40221));
        shake_sources();
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(A_CTRL, 32'h0000_0000);
        // Default picks port 0 remote pin 0; the level is computed even with the driver off
        m = exp_mux(3'h0, 3'h0, 1'b0);
        rd(A_STAT, {30'h0, m[0], 1'b0});
        // Full code sweep first, then random control words over the same tables
        for (int k = 0; k < 192; k++)
        begin
            c = (k < 64) ? {k[2:0], k[5:3], 2'($urandom)} : 8'($urandom);
            shake_sources();
            wb_xfer(1'b1, A_CTRL, {24'($urandom), c}, 4'hF);
            rd(A_CTRL, {24'h0, c});
            repeat (4) @(posedge sys_clk);
            m = exp_mux(c[4:2], c[7:5], c[1]);
            rd(A_STAT, {28'h0, m[1], c[0] & m[0], m[0], c[0]});
        end
        c = 8'($urandom);
        wb_xfer(1'b1, A_CTRL, {24'h0, c}, 4'hF);
        wb_xfer(1'b1, A_CTRL, {24'h0, ~c}, 4'hE);
        wb_xfer(1'b1, A_STAT, 32'hFFFF_FFFF, 4'hF);
        wb_xfer(1'b1, 8'h60, 32'hFFFF_FFFF, 4'hF);
        rd(A_CTRL, {24'h0, c});
        rd(8'h60, 32'h0000_0000);
        // Reset in mid-run must bring back the disabled default
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(A_CTRL, 32'h0000_0000);
        m = exp_mux(3'h0, 3'h0, 1'b0);
        rd(A_STAT, {30'h0, m[0], 1'b0});
        repeat (2) @(posedge sys_clk);
        `CHK(exp_q.size(), 0)
        conclude();
    end
endmodule // tb
